/* File: pbc_cfg.svh */
// Purpose: Offsets, field layout, reset values and codes of the pin select block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH
`define PBC_ADDR_W 4
`define PBC_OFF_PB 4'h0
`define PBC_OFF_PC 4'h4
`define PBC_PB_RST 16'h0000
`define PBC_PC_RST 16'h0000
`define PBC_GPIO_RST 8'hff
`define PBC_PB_RSVD 16'h000a
`define PBC_PB_SMALL 16'h0005
`define PBC_FLD_W 2
`define PBC_CODE_GPIO 2'h0
`define PBC_CODE_IRQ 2'h1
`define PBC_CODE_ADDR 2'h2
`define PBC_CODE_STRB 2'h3
`define PBC_RESP_OKAY 2'h0
`define PBC_RESP_SLVERR 2'h2
`endif

/* File: pbc_pkg.sv */
// Purpose: Types of the pin select block
// Assumes: Nothing
// Notes: One-hot codes written out
package pbc_pkg;
    typedef enum logic [3:0] {
        FN_GPIO = 4'h1,
        FN_IRQ = 4'h2,
        FN_ADDR = 4'h4,
        FN_STRB = 4'h8
    } pbc_func_t;
    typedef enum logic [2:0] {
        BS_IDLE = 3'h1,
        BS_BRESP = 3'h2,
        BS_RRESP = 3'h4
    } pbc_bus_st_t;
    typedef struct packed {
        pbc_bus_st_t st;
        logic awHave;
        logic wHave;
        logic [3:0] addr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awReady;
        logic wReady;
        logic arReady;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
    } pbc_bus_state_t;
    typedef struct packed {
        logic [15:0] pbReg;
        logic [15:0] pcReg;
        logic [7:0] pbGpio;
        logic [3:0] addrEn;
        logic [3:0] extIntEn;
        logic [3:0] strbEn;
        logic [15:0] pcOutEn;
    } pbc_pin_state_t;
endpackage : pbc_pkg

/* File: pbc_reg_if.sv */
// Purpose: Register access between bus slave and register file
// Assumes: One clock
// Notes: Write and read strobes are single-cycle
`timescale 1ns/1ns
`default_nettype none
`include "pbc_cfg.svh"
interface pbc_reg_if;
    logic wrEn;
    logic [`PBC_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    logic rdEn;
    logic [`PBC_ADDR_W-1:0] rdAddr;
    logic [31:0] rdData;
    logic rdOk;
    modport bus (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
        input wrOk, rdData, rdOk);
    modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
        output wrOk, rdData, rdOk);
endinterface : pbc_reg_if
`default_nettype wire

/* File: pbc_axi_slave.sv */
// Purpose: AXI4-Lite slave front end
// Assumes: One write or one read at a time
// Notes: Read answered at the accepting edge, write one edge after both halves
`timescale 1ns/1ns
`default_nettype none
`include "pbc_cfg.svh"
module pbc_axi_slave import pbc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rstN,
    input wire logic [`PBC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`PBC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    pbc_reg_if.bus bus
);
    pbc_bus_state_t r;
    pbc_bus_state_t n;

    // ----------------------------------------
    // Handshake
    // ----------------------------------------
    always_comb begin
        n = r;
        bus.wrEn = 1'b0;
        bus.wrAddr = r.addr;
        bus.wrData = r.wData;
        bus.wrStrb = r.wStrb;
        bus.rdEn = arvalid && r.arReady;
        bus.rdAddr = araddr;
        case (r.st)
            BS_IDLE: begin
                if (awvalid && r.awReady) begin
                    n.awHave = 1'b1;
                    n.addr = awaddr;
                end
                if (wvalid && r.wReady) begin
                    n.wHave = 1'b1;
                    n.wData = wdata;
                    n.wStrb = wstrb;
                end
                if (bus.rdEn) begin
                    n.st = BS_RRESP;
                    n.rValid = 1'b1;
                    n.rData = bus.rdData;
                    n.rResp = bus.rdOk ? `PBC_RESP_OKAY : `PBC_RESP_SLVERR;
                end else if (r.awHave && r.wHave) begin
                    bus.wrEn = 1'b1;
                    n.st = BS_BRESP;
                    n.awHave = 1'b0;
                    n.wHave = 1'b0;
                    n.bValid = 1'b1;
                    n.bResp = bus.wrOk ? `PBC_RESP_OKAY : `PBC_RESP_SLVERR;
                end
            end
            BS_BRESP: begin
                if (bready) begin
                    n.bValid = 1'b0;
                    n.st = BS_IDLE;
                end
            end
            BS_RRESP: begin
                if (rready) begin
                    n.rValid = 1'b0;
                    n.st = BS_IDLE;
                end
            end
            default: begin
                n.st = BS_IDLE;
                n.bValid = 1'b0;
                n.rValid = 1'b0;
            end
        endcase
        // Readies registered so no path runs from valid to ready
        n.awReady = (n.st == BS_IDLE) && !n.awHave;
        n.wReady = (n.st == BS_IDLE) && !n.wHave;
        n.arReady = (n.st == BS_IDLE) && !n.awHave && !n.wHave;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstN) begin
            r <= '{st: BS_IDLE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign awready = r.awReady;
    assign wready = r.wReady;
    assign arready = r.arReady;
    assign bvalid = r.bValid;
    assign bresp = r.bResp;
    assign rvalid = r.rValid;
    assign rresp = r.rResp;
    assign rdata = r.rData;
endmodule : pbc_axi_slave
`default_nettype wire

/* File: pbc_pin_func_select.sv */
// Purpose: Port B low pin function select and port C direction control
// Assumes: Pin inputs synchronous to ref_clk
// Notes: Pin controls registered, they follow a register write at the same edge
//
// Notes on behaviour
// R1: Field 15:14 makes pin B7 general I/O at 00, address line 19 at 10, general I/O in single-chip mode.
// R2: Field 13:12 makes pin B6 general I/O at 00, address line 18 at 10, general I/O in single-chip mode.
// R3: Field 11:10 makes pin B5 general I/O, interrupt input 3, or read/write output except in single-chip mode.
// R4: Field 9:8 makes pin B4 general I/O, interrupt input 2, or upper column strobe except in single-chip mode.
// R5: Field 7:6 makes pin B3 general I/O, interrupt input 1, or lower column strobe except in single-chip mode.
// R6: Field 5:4 makes pin B2 general I/O, interrupt input 0, or row strobe except in single-chip mode.
// R7: Bits 3 and 1 of the port B select register read 0 and software writes them 0.
// R8: Bit 2 makes pin B1 address line 17 when set, or when clear with on-chip ROM off, else general I/O.
// The code keeps pin B1 general I/O in single-chip mode and on the reduced-pin variant.
// R9: Bit 0 makes pin B0 address line 16 when set, or when clear with on-chip ROM off, else general I/O.
// The code keeps pin B0 general I/O in single-chip mode and on the reduced-pin variant.
// R10: On the reduced-pin variant bits 2 and 0 are read-only.
// R11: The port B select register clears on power-on reset and holds through watchdog reset.
// R12: The port C direction register is 16 bits, read/write, bit n for pin n.
// R13: A direction bit of 1 makes a general I/O port C pin an output, 0 an input.
// R14: A direction bit acts only while its pin is general I/O.
// R15: The port C direction register clears on power-on reset and holds through watchdog reset.
// R16: Software leaves the port C direction register alone on the reduced-pin variant.
// R17: Software avoids reserved codes of the two-bit fields.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pbc_cfg.svh"
module pbc_pin_func_select import pbc_pkg::*; #(
    parameter bit REDUCED_PINS = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic watchdogReset,
    input wire logic singleChip,
    input wire logic romDisabled,
    input wire logic [15:0] portCGpioMode,
    input wire logic [`PBC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`PBC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [7:0] pinBGpio,
    output logic [3:0] addrOutEn,
    output logic [3:0] extIntEn,
    output logic rowStrobeEn,
    output logic columnStrobeLowerEn,
    output logic columnStrobeUpperEn,
    output logic busReadWriteOutEn,
    output logic [15:0] portCOutEn
);
    // Reduced variant keeps bits 2 and 0 at zero
    localparam logic [15:0] PB_WMASK = REDUCED_PINS ?
        ~(`PBC_PB_RSVD | `PBC_PB_SMALL) : ~`PBC_PB_RSVD;

    pbc_reg_if bus ();
    pbc_pin_state_t r;
    pbc_pin_state_t n;
    logic [1:0] wrSel;
    logic [1:0] rdSel;
    pbc_func_t fn [8];

    // ----------------------------------------
    // Bus front end
    // ----------------------------------------
    // Watchdog reset restarts the bus side only
    pbc_axi_slave u_slave (
        .ref_clk(ref_clk),
        .rstN(reset_n && !watchdogReset),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] regSel(input logic [`PBC_ADDR_W-1:0] a);
        regSel = {a == `PBC_OFF_PC, a == `PBC_OFF_PB};
    endfunction : regSel

    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] val, input logic [3:0] strb);
        merge[7:0] = strb[0] ? val[7:0] : old[7:0];
        merge[15:8] = strb[1] ? val[15:8] : old[15:8];
    endfunction : merge

    // Reserved codes fall back to general I/O
    function automatic pbc_func_t fieldFunc(input logic [1:0] code,
        input logic sc, input logic addrPin);
        case (code)
            `PBC_CODE_IRQ: fieldFunc = addrPin ? FN_GPIO : FN_IRQ; // see R17
            `PBC_CODE_ADDR: fieldFunc = (addrPin && !sc) ? FN_ADDR : FN_GPIO;
            `PBC_CODE_STRB: fieldFunc = (!addrPin && !sc) ? FN_STRB : FN_GPIO;
            default: fieldFunc = FN_GPIO;
        endcase
    endfunction : fieldFunc

    function automatic pbc_func_t bitFunc(input logic sel,
        input logic sc, input logic romOff);
        if (sc) begin
            bitFunc = FN_GPIO;
        end else begin
            bitFunc = (sel || romOff) ? FN_ADDR : FN_GPIO;
        end
    endfunction : bitFunc

    // ----------------------------------------
    // Registers and pin decode
    // ----------------------------------------
    always_comb begin
        n = r;
        wrSel = regSel(bus.wrAddr);
        rdSel = regSel(bus.rdAddr);
        // Port C absent on the reduced variant, access gets an error
        bus.wrOk = wrSel[0] || (wrSel[1] && !REDUCED_PINS); // see R16
        bus.rdOk = rdSel[0] || (rdSel[1] && !REDUCED_PINS); // see R16
        bus.rdData = 32'h0;
        if (rdSel[0]) begin
            bus.rdData = {16'h0, r.pbReg}; // see R7
        end else if (rdSel[1] && !REDUCED_PINS) begin
            bus.rdData = {16'h0, r.pcReg}; // see R12
        end
        if (bus.wrEn && wrSel[0]) begin
            n.pbReg = merge(r.pbReg, bus.wrData[15:0], bus.wrStrb) & PB_WMASK; // see R7, see R10
        end
        if (bus.wrEn && wrSel[1] && !REDUCED_PINS) begin
            n.pcReg = merge(r.pcReg, bus.wrData[15:0], bus.wrStrb); // see R12
        end
        for (int i = 0; i < 8; i++) begin
            if (i < 2) begin
                fn[i] = bitFunc(n.pbReg[`PBC_FLD_W*i], singleChip, romDisabled); // see R8, see R9
                if (REDUCED_PINS) begin
                    fn[i] = FN_GPIO;
                end
            end else begin
                fn[i] = fieldFunc(n.pbReg[`PBC_FLD_W*i +: 2], singleChip, i >= 6); // see R1, see R2
            end
            n.pbGpio[i] = (fn[i] == FN_GPIO);
        end
        n.addrEn = {fn[7] == FN_ADDR, fn[6] == FN_ADDR, fn[1] == FN_ADDR, fn[0] == FN_ADDR};
        for (int i = 0; i < 4; i++) begin
            n.extIntEn[i] = (fn[i+2] == FN_IRQ); // see R3, see R4, see R5, see R6
            n.strbEn[i] = (fn[i+2] == FN_STRB); // see R3, see R4, see R5, see R6
        end
        // Direction only counts where port C pin is general I/O
        n.pcOutEn = n.pcReg & portCGpioMode; // see R13, see R14
    end

    // Only power-on reset clears, watchdog reset leaves state alone
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            r <= '{pbReg: `PBC_PB_RST, pcReg: `PBC_PC_RST, pbGpio: `PBC_GPIO_RST, default: '0}; // see R11, see R15
        end else begin
            r <= n;
        end
    end

    assign pinBGpio = r.pbGpio;
    assign addrOutEn = r.addrEn;
    assign extIntEn = r.extIntEn;
    assign rowStrobeEn = r.strbEn[0];
    assign columnStrobeLowerEn = r.strbEn[1];
    assign columnStrobeUpperEn = r.strbEn[2];
    assign busReadWriteOutEn = r.strbEn[3];
    assign portCOutEn = r.pcOutEn;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_b7_addr;
        1'b1 |=> addrOutEn[3] == (r.pbReg[15:14] == `PBC_CODE_ADDR && !$past(singleChip));
    endproperty
    a_b7_addr: assert property (p_b7_addr) else $error("pin B7 address select wrong"); // see R1

    property p_b6_gpio;
        1'b1 |=> pinBGpio[6] == (r.pbReg[13:12] != `PBC_CODE_ADDR || $past(singleChip));
    endproperty
    a_b6_gpio: assert property (p_b6_gpio) else $error("pin B6 general I/O wrong"); // see R2

    // A write at the next edge may change the field, so hold it stable first
    property p_b5_bus_read_write_out;
        r.pbReg[11:10] == `PBC_CODE_STRB && !singleChip ##1 $stable(r.pbReg) |-> busReadWriteOutEn && !pinBGpio[5];
    endproperty
    a_b5_bus_read_write_out: assert property (p_b5_bus_read_write_out) else $error("pin B5 read/write not selected"); // see R3

    property p_b4_irq;
        1'b1 |=> extIntEn[2] == (r.pbReg[9:8] == `PBC_CODE_IRQ);
    endproperty
    a_b4_irq: assert property (p_b4_irq) else $error("pin B4 interrupt select wrong"); // see R4

    property p_b3_sc;
        singleChip && r.pbReg[7:6] == `PBC_CODE_STRB ##1 $stable(r.pbReg) |-> pinBGpio[3] && !columnStrobeLowerEn;
    endproperty
    a_b3_sc: assert property (p_b3_sc) else $error("pin B3 not general I/O in single-chip"); // see R5

    property p_b2_strobe;
        1'b1 |=> rowStrobeEn == (r.pbReg[5:4] == `PBC_CODE_STRB && !$past(singleChip));
    endproperty
    a_b2_strobe: assert property (p_b2_strobe) else $error("pin B2 row strobe wrong"); // see R6

    // Only port B reads, port C direction bits may well be set
    property p_rsvd_zero;
        bus.rdEn && rdSel[0] |=> rdata[3] == 1'b0 && rdata[1] == 1'b0 && rdata[31:16] == 16'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read non-zero"); // see R7

    property p_b1_addr;
        1'b1 |=> addrOutEn[1] == (!REDUCED_PINS && !$past(singleChip) && (r.pbReg[2] || $past(romDisabled)));
    endproperty
    a_b1_addr: assert property (p_b1_addr) else $error("pin B1 address select wrong"); // see R8

    property p_b0_addr;
        1'b1 |=> addrOutEn[0] == (!REDUCED_PINS && !$past(singleChip) && (r.pbReg[0] || $past(romDisabled)));
    endproperty
    a_b0_addr: assert property (p_b0_addr) else $error("pin B0 address select wrong"); // see R9

    property p_small_ro;
        REDUCED_PINS |-> r.pbReg[2] == 1'b0 && r.pbReg[0] == 1'b0;
    endproperty
    a_small_ro: assert property (p_small_ro) else $error("read-only bits changed"); // see R10

    property p_por_clear;
        @(posedge ref_clk) disable iff (1'b0) !reset_n |=> r.pbReg == `PBC_PB_RST && r.pcReg == `PBC_PC_RST;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("power-on reset did not clear"); // see R11

    property p_wdt_hold;
        watchdogReset |=> $stable(r.pbReg) && $stable(r.pcReg);
    endproperty
    a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog reset changed registers"); // see R15

    property p_pc_write;
        bus.wrEn && wrSel[1] && bus.wrStrb[1:0] == 2'h3 && !REDUCED_PINS |=> r.pcReg == $past(bus.wrData[15:0]);
    endproperty
    a_pc_write: assert property (p_pc_write) else $error("port C direction write lost"); // see R12

    property p_pc_dir;
        1'b1 |=> portCOutEn == (r.pcReg & $past(portCGpioMode));
    endproperty
    a_pc_dir: assert property (p_pc_dir) else $error("port C direction wrong"); // see R13, see R14

    c_addr_pin: cover property (addrOutEn[3] && addrOutEn[2]);
    c_irq_pin: cover property (extIntEn[0] ##1 !extIntEn[0]);
    c_pc_out: cover property (portCOutEn != 16'h0);
    c_sc_fallback: cover property (singleChip && r.pbReg[15:14] == `PBC_CODE_ADDR);
endmodule : pbc_pin_func_select
`default_nettype wire

/* File: pbc_pin_env.sv */
// Purpose: Mode straps and port C function state facing the pin select block
// Assumes: modeSel held steady for several cycles
// Notes: Registered, so mode changes land one edge late, like sampled straps
`timescale 1ns/1ns
`default_nettype none
module pbc_pin_env (
    input wire logic ref_clk,
    input wire logic [1:0] modeSel,
    output logic singleChip,
    output logic romDisabled,
    output logic [15:0] portCGpioMode
);
    // ----------------------------------------
    // Modes: 0 normal, 1 ROM off, 2 single-chip
    // ----------------------------------------
    // ROM off puts the low port C byte on address duty
    always_ff @(posedge ref_clk) begin
        singleChip <= (modeSel == 2'h2);
        romDisabled <= (modeSel == 2'h1);
        portCGpioMode <= (modeSel == 2'h1) ? 16'hff00 : 16'hffff;
    end
endmodule : pbc_pin_env
`default_nettype wire

/* File: pbc_pin_func_select_tb.sv */
// Purpose: Self-checking bench of the pin select block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: Reserved field codes and reserved bits are never written as ones
`timescale 1ns/1ns
`default_nettype none
`include "pbc_cfg.svh"
module pbc_pin_func_select_tb;
    logic ref_clk = 1'b0;
    logic reset_n, watchdogReset, awvalid, wvalid, bready, arvalid, rready;
    logic [`PBC_ADDR_W-1:0] awaddr, araddr;
    logic [3:0] wstrb, addrOutEn, extIntEn;
    logic [31:0] wdata, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, singleChip, romDisabled;
    logic rowStrobeEn, columnStrobeLowerEn, columnStrobeUpperEn, busReadWriteOutEn;
    logic [1:0] bresp, rresp, modeSel, rsp;
    logic [15:0] portCGpioMode, portCOutEn;
    logic [7:0] pinBGpio;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] pbVals [5] = '{16'h0000, 16'ha555, 16'h0ff0, 16'h8ff1, 16'h27d4};

    always #10 ref_clk = ~ref_clk;

    pbc_pin_func_select pbc_pin_func_select_i (.ref_clk, .reset_n, .watchdogReset, .singleChip,
        .romDisabled, .portCGpioMode, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .pinBGpio, .addrOutEn, .extIntEn, .rowStrobeEn, .columnStrobeLowerEn, .columnStrobeUpperEn,
        .busReadWriteOutEn, .portCOutEn);
    pbc_pin_env pbc_pin_env_i (.ref_clk, .modeSel, .singleChip, .romDisabled, .portCGpioMode);

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        logic awPend;
        logic wPend;
        awPend = 1'b1;
        wPend = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (awPend || wPend) begin
            @(posedge ref_clk);
            if (awPend && awready === 1'b1) begin
                awvalid <= 1'b0;
                awPend = 1'b0;
            end
            if (wPend && wready === 1'b1) begin
                wvalid <= 1'b0;
                wPend = 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : bus_rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        bus_wr(a, d, s, rsp);
        check({30'h0, rsp}, {30'h0, `PBC_RESP_OKAY});
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        bus_rd(a, rd, rsp);
        check({30'h0, rsp}, {30'h0, `PBC_RESP_OKAY});
        check(rd, {16'h0, e});
    endtask : rd_chk

    // Pin roles worked out from the field codes and the mode straps
    function automatic logic [19:0] exp_pins(input logic [15:0] pb, input logic sc, input logic rom);
        logic [7:0] g;
        logic [3:0] ad;
        logic [3:0] irq;
        logic [3:0] st;
        g = 8'hff;
        ad = 4'h0;
        irq = 4'h0;
        st = 4'h0;
        if (pb[15:14] == 2'h2 && !sc) begin
            ad[3] = 1'b1;
            g[7] = 1'b0;
        end
        if (pb[13:12] == 2'h2 && !sc) begin
            ad[2] = 1'b1;
            g[6] = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            if (pb[4 + 2 * k +: 2] == 2'h1) begin
                irq[k] = 1'b1;
                g[k + 2] = 1'b0;
            end
            if (pb[4 + 2 * k +: 2] == 2'h3 && !sc) begin
                st[k] = 1'b1;
                g[k + 2] = 1'b0;
            end
        end
        if (!sc && (pb[2] || rom)) begin
            ad[1] = 1'b1;
            g[1] = 1'b0;
        end
        if (!sc && (pb[0] || rom)) begin
            ad[0] = 1'b1;
            g[0] = 1'b0;
        end
        return {g, ad, irq, st};
    endfunction : exp_pins

    // ----------------------------------------
    // Timeout and main sequence
    // ----------------------------------------
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        reset_n <= 1'b0;
        watchdogReset <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
        {awaddr, araddr, wstrb, wdata} <= '0;
        modeSel <= 2'h0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd_chk(`PBC_OFF_PB, 16'h0000);
        rd_chk(`PBC_OFF_PC, 16'h0000);
        // Reserved bits written 0, the single-bit fields beside them set
        wr(`PBC_OFF_PB, 32'h00000005, 4'h3);
        rd_chk(`PBC_OFF_PB, 16'h0005);
        wr(`PBC_OFF_PC, 32'h0000a5c3, 4'h3);
        rd_chk(`PBC_OFF_PC, 16'ha5c3);
        for (int m = 0; m < 3; m++) begin
            modeSel <= 2'(m);
            for (int i = 0; i < 5; i++) begin
                wr(`PBC_OFF_PB, {16'h0, pbVals[i]}, 4'h3);
                // Strap register plus pin register latency
                repeat (3) @(posedge ref_clk);
                check({12'h0, pinBGpio, addrOutEn, extIntEn, busReadWriteOutEn, columnStrobeUpperEn,
                    columnStrobeLowerEn, rowStrobeEn}, {12'h0, exp_pins(pbVals[i], singleChip, romDisabled)});
                check({16'h0, portCOutEn}, {16'h0, 16'ha5c3 & portCGpioMode});
            end
        end
        wr(`PBC_OFF_PC, 32'h12343c00, 4'h2);
        wr(`PBC_OFF_PC, 32'hffffffff, 4'hc);
        rd_chk(`PBC_OFF_PC, 16'h3cc3);
        bus_wr(4'h8, 32'h0000ffff, 4'hf, rsp);
        check({30'h0, rsp}, {30'h0, `PBC_RESP_SLVERR});
        bus_rd(4'h8, rd, rsp);
        check({30'h0, rsp}, {30'h0, `PBC_RESP_SLVERR});
        check(rd, 32'h0);
        watchdogReset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        watchdogReset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd_chk(`PBC_OFF_PB, pbVals[4]);
        rd_chk(`PBC_OFF_PC, 16'h3cc3);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd_chk(`PBC_OFF_PB, 16'h0000);
        rd_chk(`PBC_OFF_PC, 16'h0000);
        tally_and_finish();
    end
endmodule : pbc_pin_func_select_tb
`default_nettype wire
